//--- rtl/swd_pkg.sv
// swd_pkg: constants for the system watchdog timer
// assumes a 20 MHz system clock; no software-visible register bus
package swd_pkg;
   localparam int unsigned CLK_HZ          = 20000000;
   localparam logic [7:0]  SVC_FUNC_CODE   = 8'h6F;
   localparam logic [7:0]  SVC_SUB_SETPER  = 8'h02;
   localparam int unsigned PERIOD_W        = 8;
   localparam logic [7:0]  PERIOD_RESET    = 8'h00;
   localparam int unsigned UNIT_SEC_MS     = 1000;
   localparam int unsigned UNIT_MIN_MS     = 60000;
   localparam int unsigned UNIT_SEC_CYCLES = CLK_HZ / 1000 * UNIT_SEC_MS;
   localparam int unsigned UNIT_MIN_CYCLES = CLK_HZ / 1000 * UNIT_MIN_MS;
   localparam int unsigned TICK_W          = 31;
   localparam logic        UNIT_SEL_SEC    = 1'b0;
   localparam logic        ACTION_RESET    = 1'b0;
   localparam int unsigned RESET_PULSE_CYC = 4;
   typedef enum logic [1:0] {
      SWD_IDLE,
      SWD_RUN,
      SWD_FIRE
   } swd_state_t;
endpackage : swd_pkg

//--- rtl/swd_tick_div.sv
// swd_tick_div: divides the system clock into one-cycle unit enables
// assumes the divide count is stable while enabled; restart realigns phase
`timescale 1ns/10ps
module swd_tick_div
   import swd_pkg::*;
#(
   parameter int unsigned SEC_CYCLES = UNIT_SEC_CYCLES,
   parameter int unsigned MIN_CYCLES = UNIT_MIN_CYCLES
) (
   input  wire logic clock_i,
   input  wire logic rst_i,
   input  wire logic restart_i,
   input  wire logic run_i,
   input  wire logic unit_sel_i,
   output logic      tick_o
);
   logic [TICK_W-1:0] cnt_q;
   logic [TICK_W-1:0] cnt_d;
   wire  [TICK_W-1:0] top_w  = (unit_sel_i == UNIT_SEL_SEC) ? TICK_W'(SEC_CYCLES - 1)
                                                           : TICK_W'(MIN_CYCLES - 1); // RULE_07
   wire               wrap_w = run_i && (cnt_q >= top_w);

   assign cnt_d  = (restart_i || !run_i || wrap_w) ? '0 : cnt_q + TICK_W'(1);
   assign tick_o = wrap_w;

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule : swd_tick_div

//--- rtl/swd_watchdog.sv
// swd_watchdog: countdown watchdog loaded by a firmware service call
// assumes the call decoder presents function, sub-function and value for one cycle
// Operation
// RULE_01 - service function 6F, sub-function 2 carries the new period value
// RULE_02 - nonzero load starts countdown from value in selected units
// RULE_03 - count reaching zero triggers the expiry action
// RULE_04 - expiry gives cold reset or NMI, by configuration
// RULE_05 - each set-period call reloads the countdown, preventing expiry
// RULE_06 - loading zero stops and disables the timer
// RULE_07 - unit of one count follows the nonvolatile unit setting
// RULE_08 - software refreshes with at least ten percent margin
// RULE_09 - software writes zero before a supervised program exits
// RULE_10 - eight-bit period, range 1 to 255, clears to zero on reset
`timescale 1ns/10ps
module swd_watchdog
   import swd_pkg::*;
#(
   parameter int unsigned SEC_CYCLES = UNIT_SEC_CYCLES,
   parameter int unsigned MIN_CYCLES = UNIT_MIN_CYCLES
) (
   input  wire logic                clock_i,
   input  wire logic                rst_i,
   input  wire logic                call_valid_i,
   input  wire logic [7:0]          call_func_i,
   input  wire logic [7:0]          call_sub_i,
   input  wire logic [PERIOD_W-1:0] call_value_i,
   input  wire logic                unit_sel_i,
   input  wire logic                action_sel_i,
   output logic                     cold_reset_o,
   output logic                     nmi_o,
   output logic                     running_o,
   output logic [PERIOD_W-1:0]      count_o
);
   ////////////////////////////////////////////////////////////////////////////
   swd_state_t          state_q;
   swd_state_t          state_d;
   logic [PERIOD_W-1:0] count_q;
   logic [PERIOD_W-1:0] count_d;
   logic [2:0]          pulse_q;
   logic [2:0]          pulse_d;
   logic                rst_pulse_q;
   logic                rst_pulse_d;
   logic                nmi_q;
   logic                nmi_d;
   logic                tick_w;
   logic                run_w;
   logic                tick_run_w;
   logic                last_unit_w;
   logic                pulse_busy_w;
   logic                fire_nmi_w;

   ////////////////////////////////////////////////////////////////////////////
   // service call decode; any other function or sub-function is ignored
   wire set_period_w = call_valid_i && (call_func_i == SVC_FUNC_CODE)
                       && (call_sub_i == SVC_SUB_SETPER);                   // RULE_01
   wire load_run_w   = set_period_w && (call_value_i != '0);               // RULE_02
   wire load_off_w   = set_period_w && (call_value_i == '0);               // RULE_06

   ////////////////////////////////////////////////////////////////////////////
   // expiry is the tick that would take the count from one to zero
   assign run_w       = (state_q == SWD_RUN);
   assign tick_run_w  = run_w && tick_w;
   assign last_unit_w = (count_q == 8'h01);
   // a call in the same cycle wins, so a late refresh still holds off expiry
   wire expire_w     = tick_run_w && last_unit_w && !set_period_w;         // RULE_03
   wire fire_rst_w   = expire_w && (action_sel_i == ACTION_RESET);         // RULE_04
   assign fire_nmi_w = expire_w && (action_sel_i != ACTION_RESET);         // RULE_04

   ////////////////////////////////////////////////////////////////////////////
   // unit divider restarts on every load so a refresh gives a full unit
   swd_tick_div #(
      .SEC_CYCLES (SEC_CYCLES),
      .MIN_CYCLES (MIN_CYCLES)
   ) u_div (
      .clock_i    (clock_i),
      .rst_i      (rst_i),
      .restart_i  (set_period_w),
      .run_i      (run_w),
      .unit_sel_i (unit_sel_i),
      .tick_o     (tick_w)
   );

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_d = state_q;
      count_d = count_q;
      case (state_q)
         SWD_IDLE: begin
            if (load_run_w) begin
               state_d = SWD_RUN;                                          // RULE_02
               count_d = call_value_i;
            end
         end
         SWD_RUN: begin
            if (load_run_w) begin
               count_d = call_value_i;                                     // RULE_05
            end else if (load_off_w) begin
               state_d = SWD_IDLE;                                         // RULE_06
               count_d = '0;
            end else if (expire_w) begin
               state_d = SWD_FIRE;                                         // RULE_03
               count_d = '0;
            end else if (tick_w) begin
               count_d = count_q - 8'h01;
            end
         end
         SWD_FIRE: begin
            // one action per expiry; a new nonzero load re-arms
            if (load_run_w) begin
               state_d = SWD_RUN;
               count_d = call_value_i;
            end else if (load_off_w) begin
               state_d = SWD_IDLE;
            end
         end
         default: begin
            state_d = SWD_IDLE;
            count_d = '0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // reset pulse is stretched so the board reset logic sees it
   assign pulse_busy_w = (pulse_q != '0);
   assign pulse_d      = fire_rst_w   ? 3'(RESET_PULSE_CYC) :
                         pulse_busy_w ? pulse_q - 3'h1      : '0;
   assign rst_pulse_d  = (pulse_d != '0);                                  // RULE_04
   // nmi stays one cycle; a held level would look like a second event
   assign nmi_d        = fire_nmi_w;                                       // RULE_04

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         state_q <= SWD_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         count_q <= PERIOD_RESET;                                          // RULE_10
      end else begin
         count_q <= count_d;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         pulse_q <= '0;
      end else begin
         pulse_q <= pulse_d;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         rst_pulse_q <= 1'b0;
      end else begin
         rst_pulse_q <= rst_pulse_d;                                       // RULE_04
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         nmi_q <= 1'b0;
      end else begin
         nmi_q <= nmi_d;                                                   // RULE_04
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign cold_reset_o = rst_pulse_q;
   assign nmi_o        = nmi_q;
   assign running_o    = run_w;
   assign count_o      = count_q;
endmodule : swd_watchdog

//--- verif/swd_watchdog_monitor.sv
// swd_watchdog_monitor: port assertions for the watchdog
// assumes a bind from the bench and short unit counts
`timescale 1ns/10ps
module swd_watchdog_monitor
   import swd_pkg::*;
#(
   parameter int unsigned SEC_CYCLES = 10,
   parameter int unsigned MIN_CYCLES = 30
) (
   input logic                clock_i,
   input logic                rst_i,
   input logic                call_valid_i,
   input logic [7:0]          call_func_i,
   input logic [7:0]          call_sub_i,
   input logic [PERIOD_W-1:0] call_value_i,
   input logic                unit_sel_i,
   input logic                action_sel_i,
   input logic                cold_reset_o,
   input logic                nmi_o,
   input logic                running_o,
   input logic [PERIOD_W-1:0] count_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   wire tk = call_valid_i && call_func_i == SVC_FUNC_CODE && call_sub_i == SVC_SUB_SETPER;
   logic [31:0] gap_q;
   // restart one edge late so a reload to the same value aligns too
   always_ff @(posedge clock_i) begin
      if (rst_i || $past(tk) || $changed(count_o)) begin
         gap_q <= 32'h1;
      end else begin
         gap_q <= gap_q + 32'h1;
      end
   end
   ////////////////////////////////////////////////////////////
   chk_load_value: assert property (tk && call_value_i != 8'h00
      |=> running_o && count_o == $past(call_value_i)) else $error("load not taken");
   chk_zero_stop: assert property (tk && call_value_i == 8'h00
      |=> !running_o && count_o == 8'h00) else $error("zero load did not stop");
   chk_no_start: assert property (!tk && !running_o |=> !running_o)
      else $error("started without a valid call");
   chk_count_step: assert property (running_o && $past(running_o) && !$past(tk)
      && $changed(count_o) |-> count_o == $past(count_o) - 8'h01)
      else $error("count step wrong");
   chk_unit_time: assert property (running_o && $past(running_o) && !$past(tk)
      && $changed(count_o) |-> gap_q == (unit_sel_i ? MIN_CYCLES : SEC_CYCLES))
      else $error("unit length wrong");
   chk_reset_len: assert property ($fell(running_o) && !$past(tk)
      && !$past(action_sel_i) |-> cold_reset_o[*4] ##1 !cold_reset_o)
      else $error("reset pulse wrong");
   chk_nmi_once: assert property ($fell(running_o) && !$past(tk) && $past(action_sel_i)
      |-> nmi_o ##1 !nmi_o) else $error("nmi pulse wrong");
   chk_no_spurious: assert property ($rose(cold_reset_o) || $rose(nmi_o)
      |-> $past(running_o, 2)) else $error("action while stopped");
endmodule : swd_watchdog_monitor

//--- verif/swd_watchdog_tb.sv
// swd_watchdog_tb: self-checking bench for the watchdog
// assumes units shortened to 10 and 30 cycles
`timescale 1ns/10ps
module swd_watchdog_tb;
   import swd_pkg::*;
   localparam int SEC = 10;
   localparam int MIN = 30;
   logic clock_i = 0, rst_i = 1, call_valid_i = 0, unit_sel_i = 0, action_sel_i = 0;
   logic [7:0] call_func_i = 0, call_sub_i = 0, call_value_i = 0, count_o;
   logic cold_reset_o, nmi_o, running_o;
   int bad_count = 0, n_tests = 0, rst_cyc = 0, nmi_cyc = 0;
   always #25 clock_i = ~clock_i;
   // counted on the falling edge, clear of the design's updates
   always @(negedge clock_i) begin
      rst_cyc += int'(cold_reset_o);
      nmi_cyc += int'(nmi_o);
   end
   swd_watchdog #(.SEC_CYCLES(SEC), .MIN_CYCLES(MIN)) swd_watchdog_i (.*);
   ////////////////////////////////////////////////////////////
   function automatic int span(input int v, input int u);
      return v * (u ? MIN : SEC);
   endfunction : span
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic call(input logic [7:0] f, input logic [7:0] s, input logic [7:0] v);
      @(posedge clock_i);
      call_valid_i <= 1'b1;
      call_func_i <= f;
      call_sub_i <= s;
      call_value_i <= v;
      @(posedge clock_i);
      call_valid_i <= 1'b0;
      #1;
   endtask : call
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : print_verdict
   ////////////////////////////////////////////////////////////
   initial begin
      #250000;
      bad_count++;
      print_verdict();
   end
   initial begin
      logic [7:0] v;
      int r0, n0;
      void'($urandom(32'h415A84F4));
      repeat (2) @(posedge clock_i);
      rst_i <= 1'b0;
      #1 chk({cold_reset_o, nmi_o, running_o, count_o}, 0);
      for (int i = 0; i < 8; i++) begin
         v = (i == 0) ? 8'hFF : (i == 1) ? 8'h01 : 8'($urandom_range(255, 1));
         call(SVC_FUNC_CODE, SVC_SUB_SETPER, v);
         chk({running_o, count_o}, {1'b1, v});
      end
      call(SVC_FUNC_CODE, SVC_SUB_SETPER, 8'h00);
      chk({running_o, count_o}, 0);
      call(8'h6E, SVC_SUB_SETPER, 8'h05);
      call(SVC_FUNC_CODE, 8'h03, 8'h05);
      chk(running_o, 0);
      for (int k = 0; k < 4; k++) begin
         @(posedge clock_i);
         unit_sel_i <= k[0];
         action_sel_i <= k[1];
         r0 = rst_cyc;
         n0 = nmi_cyc;
         call(SVC_FUNC_CODE, SVC_SUB_SETPER, 8'h02);
         repeat (span(2, k % 2) - 1) @(posedge clock_i);
         #1 chk({running_o, count_o}, 9'h101);
         repeat (6) @(posedge clock_i);
         #1 chk(running_o, 0);
         chk(rst_cyc - r0, (k / 2) ? 0 : RESET_PULSE_CYC);
         chk(nmi_cyc - n0, k / 2);
      end
      n0 = nmi_cyc;
      for (int j = 0; j < 5; j++) begin
         call(SVC_FUNC_CODE, SVC_SUB_SETPER, 8'h02);
         chk(count_o, 2);
         repeat (MIN + 5) @(posedge clock_i);
      end
      call(SVC_FUNC_CODE, SVC_SUB_SETPER, 8'h00);
      repeat (3 * MIN) @(posedge clock_i);
      #1 chk(nmi_cyc - n0, 0);
      print_verdict();
   end
endmodule : swd_watchdog_tb
bind swd_watchdog swd_watchdog_monitor #(.SEC_CYCLES(SEC_CYCLES), .MIN_CYCLES(MIN_CYCLES))
   swd_watchdog_monitor_i (.*);
